// ### rtl/mode_burst_config.sv
`timescale 1ns/1ns
`default_nettype none

module mode_burst_config
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_select_bit0,
    input wire logic bank_select_bit1,
    input wire logic [mode_cfg_pkg::ADDR_W-1:0] addr,
    output logic beat_valid,
    output logic beat_is_write,
    output logic [1:0] beat_bank,
    output logic [mode_cfg_pkg::COL_W-1:0] beat_col_even,
    output logic [mode_cfg_pkg::COL_W-1:0] beat_col_odd,
    output logic burst_last,
    output logic [2:0] partial_array_refresh_select,
    output logic [2:0] drive_strength,
    output logic self_refresh_active,
    output logic deep_power_down_active,
    output logic mode_reserved
);
    import mode_cfg_pkg::*;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------

    // burst length code to block mask (length minus one)
    function automatic logic [OFF_W-1:0] len_mask(input logic [2:0] code);
        logic [OFF_W-1:0] m;
        m = 4'h0;
        unique case (code)
            BL_CODE_2: m = 4'h1;
            BL_CODE_4: m = 4'h3;
            BL_CODE_8: m = 4'h7;
            BL_CODE_16: m = 4'hf;
            default: m = 4'h0;             // reserved code, no burst
        endcase
        return m;
    endfunction : len_mask

    // column of one beat: block bits kept, offset bits wrap in block
    function automatic logic [COL_W-1:0] beat_col(
        input logic [COL_W-1:0] start,
        input logic [OFF_W-1:0] beat,
        input logic [OFF_W-1:0] mask,
        input logic inter
    );
        logic [OFF_W-1:0] low;
        low = inter ? (start[OFF_W-1:0] ^ beat)
                    : OFF_W'(start[OFF_W-1:0] + beat);
        // bits above the mask select the block, under it the start plus or xor the beat
        return {start[COL_W-1:OFF_W],
                (start[OFF_W-1:0] & ~mask) | (low & mask)};
    endfunction : beat_col

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic [1:0] bank_sel;     // bank bits as a pair
    logic cmd_mrs;            // register set command
    logic cmd_read;           // read burst
    logic cmd_write;          // write burst
    logic cmd_bst;            // terminate or deep-down entry
    logic cmd_ref;            // auto refresh or self refresh entry
    logic cke_prev_reg;       // clock enable at previous edge

    always_comb
    begin
        bank_sel = {bank_select_bit1, bank_select_bit0};
        cmd_mrs = !cs_n && !ras_n && !cas_n && !we_n;
        cmd_read = !cs_n && ras_n && !cas_n && we_n;
        cmd_write = !cs_n && ras_n && !cas_n && !we_n;
        cmd_bst = !cs_n && ras_n && cas_n && !we_n;
        cmd_ref = !cs_n && !ras_n && !cas_n && we_n;
    end

    // clock enable history for power state entries
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cke_prev_reg <= 1'b0;
        else
            cke_prev_reg <= cke;
    end

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    power_state_t pwr_reg;
    power_state_t pwr_next;
    logic enter_deep;         // deep-down entry this edge

    always_comb
    begin
        enter_deep = cke_prev_reg && !cke && cmd_bst && pwr_reg == PWR_NORMAL;
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            PWR_NORMAL:
            begin
                if (enter_deep)
                    pwr_next = PWR_DEEP_DOWN;
                else if (cke_prev_reg && !cke && cmd_ref)
                    pwr_next = PWR_SELF_REFRESH;
            end
            PWR_SELF_REFRESH:
            begin
                // exit on clock enable rising
                if (cke)
                    pwr_next = PWR_NORMAL;
            end
            PWR_DEEP_DOWN:
            begin
                if (cke)
                    pwr_next = PWR_NORMAL;
            end
            default: pwr_next = PWR_NORMAL;  // two-bit code 3 unused
        endcase
    end

    // power state register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pwr_reg <= PWR_NORMAL;
        else
            pwr_reg <= pwr_next;
    end

    // ------------------------------------------------------------
    // mode registers
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] burst_latency_config_reg;   // base register image
    logic [ADDR_W-1:0] refresh_drive_config_reg;   // extended image
    logic cmd_active;                              // commands honoured

    // commands only count with clock enable high at both edges
    assign cmd_active = cke && cke_prev_reg && pwr_reg == PWR_NORMAL;

    // base register: no documented default, cleared by reset here
    always_ff @(posedge clk)
    begin
        if (!rst_n || enter_deep)
            burst_latency_config_reg <= REG_RESET;
        else if (cmd_active && cmd_mrs && bank_sel == SEL_BASE)
            burst_latency_config_reg <= addr;
    end

    // extended register: held until rewritten or deep-down
    always_ff @(posedge clk)
    begin
        if (!rst_n || enter_deep)
            refresh_drive_config_reg <= REG_RESET;
        else if (cmd_active && cmd_mrs && bank_sel == SEL_EXT)
            refresh_drive_config_reg <= addr;
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    logic [2:0] bl_code;      // burst length field
    logic [2:0] cl_code;      // latency field
    logic bl_mask_ok;         // length code legal
    logic cl_ok;              // latency code legal
    logic [OFF_W-1:0] cur_mask;
    logic cur_inter;          // interleaved order selected

    always_comb
    begin
        bl_code = burst_latency_config_reg[BL_LSB +: 3];
        cl_code = burst_latency_config_reg[CL_LSB +: 3];
        cur_inter = burst_latency_config_reg[BT_BIT];
        cur_mask = len_mask(bl_code);
        bl_mask_ok = cur_mask != 4'h0;
        cl_ok = (cl_code == CL_CODE_2) || (cl_code == CL_CODE_3);
    end

    // ------------------------------------------------------------
    // burst launch
    // ------------------------------------------------------------
    burst_req_t new_req;      // request built from this command
    logic new_valid;          // accepted read or write
    logic new_extra;          // read with latency three
    logic stop_read;          // terminate ends a running read
    logic dly_valid;
    burst_req_t dly_req;

    // reads and writes share the one programmed length
    always_comb
    begin
        new_req.is_write = cmd_write;
        new_req.bank = bank_sel;
        new_req.col = addr[COL_W-1:0];
        new_req.mask = cur_mask;
        new_req.interleave = cur_inter;
        // a reserved mode makes the device ignore bursts
        new_valid = cmd_active && (cmd_read || cmd_write) && bl_mask_ok && cl_ok;
        // latency three adds a second stage: data at n + 2 clocks
        new_extra = cmd_read && (cl_code == CL_CODE_3);
        stop_read = cmd_active && cmd_bst && !beat_is_write;
    end

    // latency two launches after one stage: data at n + 1 clock
    launch_delay u_launch
    (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(new_valid),
        .in_extra(new_extra),
        .in_req(new_req),
        .flush(enter_deep),
        .out_valid(dly_valid),
        .out_req(dly_req)
    );

    // ------------------------------------------------------------
    // burst engine: two beats per clock, one per edge
    // ------------------------------------------------------------
    burst_req_t run_reg;           // burst in progress
    logic running_reg;             // a burst still has beats left
    logic [OFF_W-1:0] beat_reg;    // next even beat index
    burst_req_t src;               // burst that drives this cycle
    logic [OFF_W-1:0] src_beat;
    logic src_go;
    logic src_last;

    // a newly launched burst interrupts the running one
    always_comb
    begin
        src_go = dly_valid || running_reg;
        src = dly_valid ? dly_req : run_reg;
        src_beat = dly_valid ? 4'h0 : beat_reg;
        src_last = OFF_W'(src_beat + 4'h1) == src.mask;
    end

    // beat counter and burst hold
    always_ff @(posedge clk)
    begin
        if (!rst_n || enter_deep)
        begin
            running_reg <= 1'b0;
            beat_reg <= 4'h0;
        end
        else if (stop_read && !dly_valid)
            running_reg <= 1'b0;       // terminate frees the bus at once
        else if (src_go)
        begin
            running_reg <= !src_last;
            beat_reg <= OFF_W'(src_beat + BEATS_PER_CLK);
        end
        if (dly_valid)
            run_reg <= dly_req;
    end

    // beat outputs, all registered
    always_ff @(posedge clk)
    begin
        if (!rst_n || enter_deep)
        begin
            beat_valid <= 1'b0;
            beat_is_write <= 1'b0;
            beat_bank <= 2'h0;
            beat_col_even <= '0;
            beat_col_odd <= '0;
            burst_last <= 1'b0;
        end
        else if (src_go && !(stop_read && !dly_valid))
        begin
            beat_valid <= 1'b1;
            beat_is_write <= src.is_write;
            beat_bank <= src.bank;
            beat_col_even <= beat_col(src.col, src_beat, src.mask,
                                      src.interleave);
            beat_col_odd <= beat_col(src.col, OFF_W'(src_beat + 4'h1),
                                     src.mask, src.interleave);
            burst_last <= src_last;
        end
        else
        begin
            beat_valid <= 1'b0;
            burst_last <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // extended register effects and status
    // ------------------------------------------------------------

    // refresh area only counts in self refresh, full array otherwise
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            partial_array_refresh_select <= PAR_FULL;
        else if (pwr_next == PWR_SELF_REFRESH)
            partial_array_refresh_select <=
                refresh_drive_config_reg[PAR_LSB +: 3];
        else
            partial_array_refresh_select <= PAR_FULL;
    end

    // drive strength follows the register one clock later
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            drive_strength <= 3'h0;
        else
            drive_strength <= refresh_drive_config_reg[DRV_LSB +: 3];
    end

    // power flags and reserved-code flag
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            self_refresh_active <= 1'b0;
            deep_power_down_active <= 1'b0;
            mode_reserved <= 1'b1;
        end
        else
        begin
            self_refresh_active <= pwr_next == PWR_SELF_REFRESH;
            deep_power_down_active <= pwr_next == PWR_DEEP_DOWN;
            // reserved codes block bursts; the controller must avoid them
            mode_reserved <= !(bl_mask_ok && cl_ok);
        end
    end

endmodule : mode_burst_config

`default_nettype wire

// ### rtl/mode_cfg_pkg.sv
package mode_cfg_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 14;  // address pins, register image width
    localparam int COL_W = 10;   // column address bits
    localparam int OFF_W = 4;    // in-block offset, up to sixteen beats

    // ------------------------------------------------------------
    // base register field positions
    // ------------------------------------------------------------
    localparam int BL_LSB = 0;   // burst length code, three bits
    localparam int BT_BIT = 3;   // burst type, 1 = interleaved
    localparam int CL_LSB = 4;   // read latency code, three bits

    // ------------------------------------------------------------
    // extended register field positions
    // ------------------------------------------------------------
    localparam int PAR_LSB = 0;  // partial array refresh select
    localparam int DRV_LSB = 5;  // output drive strength

    // ------------------------------------------------------------
    // codes and values after reset
    // ------------------------------------------------------------
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [2:0] BL_CODE_16 = 3'h4;
    localparam logic [2:0] CL_CODE_2 = 3'h2;
    localparam logic [2:0] CL_CODE_3 = 3'h3;
    localparam logic [2:0] PAR_FULL = 3'h0;   // whole array kept
    localparam logic [ADDR_W-1:0] REG_RESET = 14'h0000;
    localparam logic [1:0] SEL_BASE = 2'h0;   // bank bits 1,0 = 0,0
    localparam logic [1:0] SEL_EXT = 2'h2;    // bank bits 1,0 = 1,0
    localparam logic [OFF_W-1:0] BEATS_PER_CLK = 4'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic is_write;            // write burst, else read
        logic [1:0] bank;          // bank of the burst
        logic [COL_W-1:0] col;     // starting column
        logic [OFF_W-1:0] mask;    // burst length minus one
        logic interleave;          // column order
    } burst_req_t;

    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_SELF_REFRESH,
        PWR_DEEP_DOWN
    } power_state_t;

endpackage : mode_cfg_pkg

// ### rtl/launch_delay.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// burst launch delay: one stage always, a second stage on request
// ------------------------------------------------------------
module launch_delay
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic in_extra,
    input wire mode_cfg_pkg::burst_req_t in_req,
    input wire logic flush,
    output logic out_valid,
    output mode_cfg_pkg::burst_req_t out_req
);
    import mode_cfg_pkg::*;

    logic s1_valid_reg;      // first stage, launches directly
    logic s1_extra_reg;      // first stage wants one more cycle
    burst_req_t s1_req_reg;
    logic s2_valid_reg;      // second stage
    burst_req_t s2_req_reg;

    // stage one takes every command
    always_ff @(posedge clk)
    begin
        if (!rst_n || flush)
        begin
            s1_valid_reg <= 1'b0;
            s1_extra_reg <= 1'b0;
        end
        else
        begin
            s1_valid_reg <= in_valid;
            s1_extra_reg <= in_extra;
        end
        s1_req_reg <= in_req;
    end

    // stage two only for the longer latency
    always_ff @(posedge clk)
    begin
        if (!rst_n || flush)
            s2_valid_reg <= 1'b0;
        else
            s2_valid_reg <= s1_valid_reg && s1_extra_reg;
        s2_req_reg <= s1_req_reg;
    end

    // the second stage wins; a newer short command in the same cycle is dropped
    always_comb
    begin
        out_valid = s2_valid_reg || (s1_valid_reg && !s1_extra_reg);
        out_req = s2_valid_reg ? s2_req_reg : s1_req_reg;
    end

endmodule : launch_delay

`default_nettype wire

// ### test/cmd_driver.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// memory controller model on the command bus
// ----------------------------------------
module cmd_driver
#(
    parameter int SET_GAP = 2  // register set cycle time, clocks
)
(
    input wire logic clk,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic bank_select_bit0,
    output logic bank_select_bit1,
    output logic [mode_cfg_pkg::ADDR_W-1:0] addr
);
    import mode_cfg_pkg::*;

    // idle bus: deselected, clock enabled
    initial
    begin
        cke = 1'b1;
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = 3'h7;
        {bank_select_bit1, bank_select_bit0} = 2'h0;
        addr = '0;
    end

    // one command for one clock, then deselect
    task automatic issue(input logic [2:0] rcw, input logic [1:0] ba,
                         input logic [ADDR_W-1:0] a, input logic ck);
        @(posedge clk);
        #1;
        cs_n = 1'b0;
        {ras_n, cas_n, we_n} = rcw;
        {bank_select_bit1, bank_select_bit0} = ba;
        addr = a;
        cke = ck;
        @(posedge clk);
        #1;
        cs_n = 1'b1;
        addr = ~addr;  // no stale address once released
    endtask : issue

    // register set, bursts all finished
    task automatic set_reg(input logic [1:0] sel, input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] keep;
        keep = (sel == SEL_EXT) ? 14'h00e7 : 14'h007f;  // unused bits zero
        issue(3'h0, sel, a & keep, 1'b1);  // bank bits pick the register
        repeat (SET_GAP) @(posedge clk);  // set cycle time
        #1;
    endtask : set_reg

    // leave self refresh or deep power down
    task automatic wake();
        @(posedge clk);
        #1;
        cke = 1'b1;
        repeat (2) @(posedge clk);
    endtask : wake
endmodule : cmd_driver
`default_nettype wire

// ### test/burst_rules_sva.sv
`timescale 1ns/1ns
`default_nettype none
module burst_rules_check
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_select_bit0,
    input wire logic bank_select_bit1,
    input wire logic [mode_cfg_pkg::ADDR_W-1:0] addr,
    input wire logic beat_valid,
    input wire logic beat_is_write,
    input wire logic [1:0] beat_bank,
    input wire logic [mode_cfg_pkg::COL_W-1:0] beat_col_even,
    input wire logic [mode_cfg_pkg::COL_W-1:0] beat_col_odd,
    input wire logic burst_last,
    input wire logic [2:0] partial_array_refresh_select,
    input wire logic [2:0] drive_strength,
    input wire logic self_refresh_active,
    input wire logic deep_power_down_active,
    input wire logic mode_reserved
);
    import mode_cfg_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // helper logic: which commands the device takes
    // ----------------------------------------
    logic cke_q;  // cke seen at the previous edge
    logic [2:0] cl_q;  // latency code last written
    logic [2:0] bl_q;  // length code last written
    wire logic [1:0] sel = {bank_select_bit1, bank_select_bit0};
    wire logic live = cke && cke_q && !cs_n && !self_refresh_active && !deep_power_down_active;
    wire logic set_cmd = live && !ras_n && !cas_n && !we_n;
    wire logic ext_set = set_cmd && sel == SEL_EXT;
    wire logic rw_cmd = live && ras_n && !cas_n && !mode_reserved;
    wire logic bad_now = addr[2:0] == 3'h0 || addr[2:0] > BL_CODE_16
        || !(addr[6:4] == CL_CODE_2 || addr[6:4] == CL_CODE_3);

    // low through reset, like the device
    always_ff @(posedge clk)
    begin
        cke_q <= rst_n & cke;
    end

    // shadow of the base fields
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cl_q <= 3'h0;
            bl_q <= 3'h0;
        end
        else if (set_cmd && sel == SEL_BASE)
        begin
            cl_q <= addr[CL_LSB+:3];
            bl_q <= addr[BL_LSB+:3];
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    par_gate_a: assert property (
        !self_refresh_active |-> partial_array_refresh_select == PAR_FULL)
        else $error("refresh select outside self refresh");
    pair_order_a: assert property (
        beat_valid |-> beat_col_odd[0] != beat_col_even[0]
        && beat_col_odd[9:4] == beat_col_even[9:4]) else $error("beat pair leaves block");
    base_code_a: assert property (
        set_cmd && sel == SEL_BASE |-> ##3 mode_reserved == $past(bad_now, 3))
        else $error("reserved flag wrong");
    ext_fields_a: assert property (
        ext_set |-> ##3 drive_strength == $past(addr[DRV_LSB+:3], 3))
        else $error("drive field wrong");
    drive_hold_a: assert property (
        drive_strength != $past(drive_strength) |-> $past(ext_set, 2) || $past(ext_set, 3)
        || $past(deep_power_down_active)) else $error("drive strength drifted");
    write_lat_a: assert property (
        rw_cmd && !we_n && !beat_valid && !$past(rw_cmd) && !$past(rw_cmd, 2)
        |-> ##1 !beat_valid ##1 beat_valid && beat_is_write)
        else $error("write beats late or early");
    read_two_a: assert property (
        rw_cmd && we_n && cl_q == CL_CODE_2 && !beat_valid && !$past(rw_cmd)
        && !$past(rw_cmd, 2) |-> ##1 !beat_valid ##1 beat_valid && !beat_is_write)
        else $error("latency two read mistimed");
    read_three_a: assert property (
        rw_cmd && we_n && cl_q == CL_CODE_3 && !beat_valid && !$past(rw_cmd)
        && !$past(rw_cmd, 2) |-> ##1 !beat_valid [*2] ##1 beat_valid && !beat_is_write)
        else $error("latency three read mistimed");
    two_last_a: assert property (
        beat_valid && bl_q == BL_CODE_2 |-> burst_last) else $error("length two not one pair");
    eight_run_a: assert property (
        $rose(beat_valid) && bl_q == BL_CODE_8 |-> !burst_last [*3] ##1 burst_last)
        else $error("length eight not four pairs");
    dpd_clear_a: assert property (
        $rose(deep_power_down_active) |-> ##1 drive_strength == 3'h0 && mode_reserved
        && !beat_valid) else $error("deep power down kept state");

    // main scenarios reached
    cover property (burst_last && beat_is_write);
    cover property (burst_last && !beat_is_write);
    cover property (self_refresh_active && partial_array_refresh_select != PAR_FULL);
    cover property ($rose(deep_power_down_active));
endmodule : burst_rules_check

bind mode_burst_config burst_rules_check chk (.*);
`default_nettype wire

// ### test/lpddr_mode_burst_config_bench.sv
`timescale 1ns/1ns
`default_nettype none
module lpddr_mode_burst_config_bench;
    import mode_cfg_pkg::*;
    localparam int LIMIT = 20000;  // runs need a few hundred
    logic clk;
    logic rst_n;
    wire logic cke, cs_n, ras_n, cas_n, we_n, bank_select_bit0, bank_select_bit1;
    wire logic [ADDR_W-1:0] addr;
    logic beat_valid, beat_is_write, burst_last;
    logic self_refresh_active, deep_power_down_active, mode_reserved;
    logic [1:0] beat_bank;
    logic [COL_W-1:0] beat_col_even, beat_col_odd;
    logic [2:0] partial_array_refresh_select, drive_strength;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    // ----------------------------------------
    // controller model and device
    // ----------------------------------------
    cmd_driver ctl (.*);
    mode_burst_config DUT (.*);

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            miscompares++;
            conclude();
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    // column of beat b: block bits kept, low bits wrap or flip
    function automatic logic [9:0] exp_col(input logic [9:0] s, input int b, input int len,
                                           input logic il);
        logic [9:0] m;
        m = 10'(len - 1);
        exp_col = (s & ~m) | ((il ? (s ^ 10'(b)) : (s + 10'(b))) & m);
    endfunction : exp_col

    // one read or write, every pair compared
    task automatic burst(input logic [2:0] blc, input logic il, input logic [2:0] cl,
                         input logic wr, input logic [1:0] ba, input logic [9:0] col);
        int len;
        int lat;
        len = 2 << (int'(blc) - 1);
        lat = (wr || cl == CL_CODE_2) ? 1 : 2;
        ctl.issue({2'b10, ~wr}, ba, {4'h0, col}, 1'b1);
        repeat (lat) @(posedge clk);
        #1;
        for (int k = 0; k < len; k += 2)
        begin
            check("beat valid", beat_valid, 1'b1);
            check("beat direction", beat_is_write, wr);
            check("beat bank", beat_bank, ba);
            check("even column", beat_col_even, exp_col(col, k, len, il));
            check("odd column", beat_col_odd, exp_col(col, k + 1, len, il));
            check("last pair", burst_last, k + 2 == len);
            @(posedge clk);
            #1;
        end
        check("burst ended", beat_valid, 1'b0);
    endtask : burst

    // verdict and end of run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [2:0] cl;
        logic [2:0] drv;
        logic [2:0] par;
        logic [9:0] col;
        rst_n = 1'b0;
        void'($urandom(7399));
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check("reserved after reset", mode_reserved, 1'b1);
        @(posedge clk);
        // every length and order; first eight start at the top column
        for (int r = 0; r < 48; r++)
        begin
            cl = ($urandom % 2) ? CL_CODE_3 : CL_CODE_2; // only legal latencies
            col = (r < 8) ? 10'h3ff : 10'($urandom);
            ctl.set_reg(SEL_BASE, {7'h0, cl, 1'((r / 4) % 2), 3'(1 + r % 4)});
            check("base legal", mode_reserved, 1'b0);
            burst(3'(1 + r % 4), 1'((r / 4) % 2), cl, 1'($urandom), 2'($urandom), col);
        end
        // terminate cuts a running read
        ctl.set_reg(SEL_BASE, {7'h0, CL_CODE_2, 1'b0, BL_CODE_4});
        ctl.issue(3'h5, 2'h0, 14'h0, 1'b1);
        ctl.issue(3'h6, 2'h0, 14'h0, 1'b1);
        check("terminated", beat_valid, 1'b0);
        $display("test bursts done");
        // extended register, self refresh, deep power down
        drv = 3'($urandom);
        par = 3'($urandom) | 3'h1;
        ctl.set_reg(SEL_EXT, {6'h0, drv, 2'h0, par});
        @(posedge clk);
        #1;
        check("drive", drive_strength, drv);
        check("select idle", partial_array_refresh_select, PAR_FULL);
        ctl.set_reg(2'h1, 14'h00e0);
        check("drive kept", drive_strength, drv);
        ctl.issue(3'h1, 2'h0, 14'h0, 1'b0);
        @(posedge clk);
        #1;
        check("self refresh", self_refresh_active, 1'b1);
        check("select in refresh", partial_array_refresh_select, par);
        ctl.wake();
        #1;
        check("select after", partial_array_refresh_select, PAR_FULL);
        check("drive held", drive_strength, drv);
        ctl.issue(3'h6, 2'h0, 14'h0, 1'b0);
        @(posedge clk);
        #1;
        check("deep down", deep_power_down_active, 1'b1);
        ctl.wake();
        #1;
        check("drive cleared", drive_strength, 3'h0);
        check("base cleared", mode_reserved, 1'b1);
        $display("test extended done");
        // reserved length, then reserved latency: no burst starts
        for (int i = 0; i < 2; i++)
        begin
            // reserved codes sent only here, on purpose
            ctl.set_reg(SEL_BASE, i ? {7'h0, 3'h1, 1'b0, BL_CODE_4} : {7'h0, CL_CODE_2, 4'h5});
            check("reserved code", mode_reserved, 1'b1);
            ctl.issue(3'h5, 2'h0, 14'h0, 1'b1);
            repeat (4)
            begin
                check("refused burst", beat_valid, 1'b0);
                #10;
            end
        end
        $display("test reserved done");
        conclude();
    end
endmodule : lpddr_mode_burst_config_bench
`default_nettype wire
